// ---- hw/line_event_summary_cfg_regs.sv ----
`timescale 1ns/1ps
module line_event_summary_cfg_regs
  import dio_cfg_pkg::*;
#(
  parameter int NUM_LINES = LINES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire reg_req_t req,
  output logic [31:0] rdata,
  input wire logic [NUM_LINES-1:0] line_in,
  input wire logic [NUM_LINES-1:0] rise_enable,
  input wire logic [NUM_LINES-1:0] fall_enable,
  input wire logic [15:0] sample_in,
  output logic [15:0] sample_to_host,
  output logic line_event_summary,
  output logic acknowledge_mode_select,
  output logic transfer_byte_order,
  output logic [1:0] front_pull_select,
  output logic [1:0] back_pull_select
);
  // line history and edge decode
  logic [NUM_LINES-1:0] line_q;
  logic [NUM_LINES-1:0] rise_hit;
  logic [NUM_LINES-1:0] fall_hit;
  logic [NUM_LINES-1:0] edge_hit;

  // pending flags and the two acknowledge paths
  logic [NUM_LINES-1:0] pending;
  logic [NUM_LINES-1:0] next_pending;
  logic [NUM_LINES-1:0] write_clear;
  logic [NUM_LINES-1:0] read_clear;
  logic [NUM_LINES-1:0] clear_mask;

  // address decode and access strobes
  logic hit_status;
  logic hit_global;
  logic hit_front;
  logic hit_back;
  logic rd_status;
  logic wr_status;
  logic wr_global;
  logic wr_front;
  logic wr_back;

  // read-back words, one for each register
  logic [31:0] status_word;
  logic [31:0] global_word;
  logic [31:0] front_word;
  logic [31:0] back_word;

  // sample path
  logic [15:0] next_sample;

  // swaps the two bytes of a sample when big-endian order is chosen
  function automatic logic [15:0] order_bytes(input logic [15:0] v,
                                              input logic big);
    if (big) begin
      order_bytes = {v[7:0], v[15:8]};
    end else begin
      order_bytes = v;
    end
  endfunction

  // one offset compare, shared by the write strobes and the status read strobe
  function automatic logic addr_match(input logic [ADDR_W-1:0] a,
                                      input logic [ADDR_W-1:0] ofs);
    addr_match = (a == ofs);
  endfunction

  // places a 2-bit pull field in an otherwise zero register word
  function automatic logic [31:0] pull_word(input logic [1:0] sel);
    pull_word = 32'h0;
    pull_word[1:0] = sel;
  endfunction

  // address decode; only the four offsets of this group are claimed,
  // every other offset is left to the neighbouring register groups
  assign hit_status = addr_match(req.addr, LINE_STATUS_OFS);
  assign hit_global = addr_match(req.addr, GLOBAL_CFG_OFS);
  assign hit_front = addr_match(req.addr, FRONT_PULL_OFS);
  assign hit_back = addr_match(req.addr, BACK_PULL_OFS);

  // each strobe lasts one cycle; a strobe held longer acts again,
  // which would clear a second time in read-to-clear mode
  assign rd_status = req.rd && hit_status;
  assign wr_status = req.wr && hit_status;
  assign wr_global = req.wr && hit_global;
  assign wr_front = req.wr && hit_front;
  assign wr_back = req.wr && hit_back;

  // previous line level; starting at zero means a line high at reset
  // shows one rising edge on the first cycle
  // limitation: lines that idle high need their enables set after reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      line_q <= '0;
    end else begin
      line_q <= line_in;
    end
  end

  // an edge only counts when its direction is enabled for that line
  assign rise_hit = line_in & ~line_q & rise_enable;
  assign fall_hit = ~line_in & line_q & fall_enable;
  assign edge_hit = rise_hit | fall_hit;

  // write-one-to-clear only acts in acknowledge mode 0
  // write data above the line count is dropped
  always_comb begin
    write_clear = '0;
    if (wr_status && !acknowledge_mode_select) begin
      write_clear = req.wdata[NUM_LINES-1:0];
    end
  end

  // a status read wipes the whole register in acknowledge mode 1
  always_comb begin
    read_clear = '0;
    if (rd_status && acknowledge_mode_select) begin
      read_clear = '1;
    end
  end

  assign clear_mask = write_clear | read_clear;

  // set beats clear so an edge in the acknowledge cycle is not lost
  always_comb begin
    next_pending = (pending & ~clear_mask) | edge_hit;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pending <= '0;
    end else begin
      pending <= next_pending;
    end
  end

  // the summary is a plain OR, so it drops in the same cycle as the
  // last flag and never needs its own acknowledge
  assign line_event_summary = |pending;

  // unmapped offsets and reserved bits are ignored on write
  // the mode bit steers both clear paths from the next cycle on
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acknowledge_mode_select <= 1'h0;
    end else if (wr_global) begin
      acknowledge_mode_select <= req.wdata[ACK_MODE_BIT];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      transfer_byte_order <= 1'h0;
    end else if (wr_global) begin
      transfer_byte_order <= req.wdata[BYTE_ORDER_BIT];
    end
  end

  // pull codes go straight to the resistor switches; 00 leaves the
  // lines floating so nothing fights an external driver at power-up
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      front_pull_select <= PULL_RESET;
    end else if (wr_front) begin
      front_pull_select <= req.wdata[1:0];
    end
  end

  // the back lines share the front encoding but have their own field
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      back_pull_select <= PULL_RESET;
    end else if (wr_back) begin
      back_pull_select <= req.wdata[1:0];
    end
  end

  // the byte swap sits on the sample path that feeds the transfer engine
  // registered so the swap does not lengthen the path to host memory
  always_comb begin
    next_sample = order_bytes(sample_in, transfer_byte_order);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sample_to_host <= 16'h0;
    end else begin
      sample_to_host <= next_sample;
    end
  end

  // reserved bits read back as zero in every word
  always_comb begin
    status_word = 32'h0;
    status_word[NUM_LINES-1:0] = pending;
  end

  always_comb begin
    global_word = 32'h0;
    global_word[ACK_MODE_BIT] = acknowledge_mode_select;
    global_word[BYTE_ORDER_BIT] = transfer_byte_order;
  end

  assign front_word = pull_word(front_pull_select);
  assign back_word = pull_word(back_pull_select);

  // combinational read data, valid in the cycle rd is high; the host
  // must hold the address steady while it samples
  always_comb begin
    rdata = 32'h0;
    if (req.rd) begin
      case (req.addr)
        LINE_STATUS_OFS: rdata = status_word;
        GLOBAL_CFG_OFS: rdata = global_word;
        FRONT_PULL_OFS: rdata = front_word;
        BACK_PULL_OFS: rdata = back_word;
        default: rdata = 32'h0;
      endcase
    end
  end
endmodule

// ---- include/dio_cfg_pkg.sv ----
package dio_cfg_pkg;
  localparam int ADDR_W = 12;
  localparam int LINES = 14;
  localparam logic [ADDR_W-1:0] LINE_STATUS_OFS = 12'h38C;
  localparam logic [ADDR_W-1:0] GLOBAL_CFG_OFS = 12'h398;
  localparam logic [ADDR_W-1:0] FRONT_PULL_OFS = 12'h39C;
  localparam logic [ADDR_W-1:0] BACK_PULL_OFS = 12'h3A0;
  localparam int BYTE_ORDER_BIT = 0;
  localparam int ACK_MODE_BIT = 1;
  localparam int SUMMARY_BIT = 31;
  localparam logic [1:0] PULL_RESET = 2'h0;
  localparam logic [1:0] PULL_FLOAT = 2'h0;
  localparam logic [1:0] PULL_UP_5V = 2'h1;
  localparam logic [1:0] PULL_UP_3V3 = 2'h2;
  localparam logic [1:0] PULL_DOWN = 2'h3;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } reg_req_t;
endpackage

// ---- verification/dio_regs_checker.sv ----
`timescale 1ns/1ps
module dio_regs_checker import dio_cfg_pkg::*; (
  input wire logic clk, rstn, line_event_summary, acknowledge_mode_select,
  input wire reg_req_t req,
  input wire logic [31:0] rdata,
  input wire logic [13:0] line_in, rise_enable,
  input wire logic [1:0] front_pull_select, back_pull_select);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic up;
  wire st = req.rd && req.addr == LINE_STATUS_OFS;
  wire [1:0] wd = req.wdata[1:0];
  // masks the first edge after reset, where $past still sees reset values
  always_ff @(posedge clk) up <= rstn;
  a_front_wr: assert property (req.wr && req.addr == FRONT_PULL_OFS
    |=> front_pull_select == $past(wd)) else $error("front");
  a_back_wr: assert property (req.wr && req.addr == BACK_PULL_OFS
    |=> back_pull_select == $past(wd)) else $error("back");
  a_mode_wr: assert property (req.wr && req.addr == GLOBAL_CFG_OFS
    |=> acknowledge_mode_select == $past(wd[1])) else $error("mode");
  a_pull_reset: assert property (!up |-> front_pull_select == 0
    && back_pull_select == 0) else $error("pull");
  a_stat_read: assert property (st |-> rdata[31:14] == 0
    && line_event_summary == |rdata) else $error("stat");
  a_edge_set: assert property (up && |(rise_enable & line_in
    & ~$past(line_in)) |=> line_event_summary) else $error("edge");
  a_read_clr: assert property (up && st && acknowledge_mode_select
    && $stable(line_in) |=> !line_event_summary) else $error("clear");
  a_read_keep: assert property (up && st && !acknowledge_mode_select
    && $stable(line_in) |=> $stable(line_event_summary)) else $error("keep");
endmodule
bind line_event_summary_cfg_regs dio_regs_checker i_chk(.*);

// ---- verification/host_model.sv ----
`timescale 1ns/1ps
module host_model import dio_cfg_pkg::*; (
  input wire logic clk,
  output reg_req_t req = '0,
  input wire logic [31:0] rdata);
  // read data is taken at the edge that accepts the strobe
  task automatic acc(bit w, logic [11:0] a, logic [31:0] d,
    output logic [31:0] q);
    @(posedge clk);
    #5 req = {!w, w, a, d};
    @(posedge clk);
    q = rdata;
    #5 req = '0;
  endtask
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
module tb_top import dio_cfg_pkg::*;;
  logic clk = 0, rstn = 0, line_event_summary, transfer_byte_order;
  logic acknowledge_mode_select;
  logic [1:0] front_pull_select, back_pull_select;
  logic [13:0] line_in = 0;
  logic [15:0] sample_to_host;
  logic [31:0] rdata, q;
  reg_req_t req;
  int num_errors = 0, comparisons = 0, cyc = 0;
  always #50 clk = ~clk;
  line_event_summary_cfg_regs i_dut(.*, .rise_enable(14'h1), .fall_enable(14'h2000),
    .sample_in(16'h1234));
  host_model i_host(.*);
  task automatic chk(logic [31:0] g, e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t %h %h", $time, g, e);
    end
  endtask
  task automatic close_out;
    if (num_errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) if (++cyc > 999) begin
    num_errors++;
    close_out;
  end
  task automatic rd(logic [11:0] a, logic [31:0] e);
    i_host.acc(0, a, 0, q);
    chk(q, e);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #5 rstn = 1;
    rd(FRONT_PULL_OFS, 0);
    rd(BACK_PULL_OFS, 0);
    rd(GLOBAL_CFG_OFS, 0);
    for (int k = 0; k < 4; k++) begin
      i_host.acc(1, FRONT_PULL_OFS, k, q);
      i_host.acc(1, BACK_PULL_OFS, 3 - k, q);
      rd(FRONT_PULL_OFS, k);
      rd(BACK_PULL_OFS, 3 - k);
    end
    chk(sample_to_host, 16'h1234);
    chk(transfer_byte_order, 0);
    line_in = '1;
    rd(LINE_STATUS_OFS, 1);
    chk(line_event_summary, 1);
    line_in = 0;
    rd(LINE_STATUS_OFS, 32'h2001);
    i_host.acc(1, LINE_STATUS_OFS, 1, q);
    rd(LINE_STATUS_OFS, 32'h2000);
    // a rising edge on line 0 lands in the very cycle of its clear
    fork
      i_host.acc(1, LINE_STATUS_OFS, 1, q);
      begin
        @(posedge clk);
        #5 line_in = 14'h1;
      end
    join
    rd(LINE_STATUS_OFS, 32'h2001);
    i_host.acc(1, GLOBAL_CFG_OFS, 3, q);
    rd(GLOBAL_CFG_OFS, 3);
    chk(acknowledge_mode_select, 1);
    rd(LINE_STATUS_OFS, 32'h2001);
    rd(LINE_STATUS_OFS, 0);
    chk(line_event_summary, 0);
    chk(sample_to_host, 16'h3412);
    chk(transfer_byte_order, 1);
    close_out;
  end
endmodule
